/* isme_consts.vh */
// constants for the increment-skip / or / move-literal execute block
`ifndef ISME_CONSTS_VH
`define ISME_CONSTS_VH

// instruction word layout
`define ISME_WORD_W          14
`define ISME_DATA_W          8
`define ISME_FADDR_W         7
`define ISME_DEST_BIT        7
`define ISME_OP6_HI          13
`define ISME_OP6_LO          8
`define ISME_OP4_LO          10

// opcode patterns (upper six bits, or upper four for the literal load)
`define ISME_OP_INCSKIP      6'h0f
`define ISME_OP_ORFILE       6'h04
`define ISME_OP_ORLIT        6'h38
`define ISME_OP_LOADLIT      4'hc

// decoded operation classes
`define ISME_CLS_W           3
`define ISME_CLS_NOP         3'h0
`define ISME_CLS_INCSKIP     3'h1
`define ISME_CLS_ORFILE      3'h2
`define ISME_CLS_LOADLIT     3'h3
`define ISME_CLS_ORLIT       3'h4

// timing: one instruction cycle is four oscillator periods
`define ISME_OSC_PERIOD_NS   10
`define ISME_OSC_PER_INSTR   4
`define ISME_PHASE_W         2
`define ISME_PHASE_LAST      2'h3

// reset values
`define ISME_ACC_RESET       8'h00

`endif

/* isme_decode.v */
// opcode decoder for the execute block
`timescale 1ns/100ps
`include "isme_consts.vh"

module isme_decode (
  // instruction word in
  input  wire [`ISME_WORD_W-1:0] word,
  // decoded class out
  output reg  [`ISME_CLS_W-1:0]  op_class,
  output reg                     known
);

  wire [5:0] op6;
  wire [3:0] op4;

  assign op6 = word[`ISME_OP6_HI:`ISME_OP6_LO];
  assign op4 = word[`ISME_OP6_HI:`ISME_OP4_LO];

  always @* begin
    op_class = `ISME_CLS_NOP;
    known    = 1'b1;
    if (op6 == `ISME_OP_INCSKIP) begin
      op_class = `ISME_CLS_INCSKIP;
    end else if (op6 == `ISME_OP_ORFILE) begin
      op_class = `ISME_CLS_ORFILE;
    end else if (op6 == `ISME_OP_ORLIT) begin
      op_class = `ISME_CLS_ORLIT;
    end else if (op4 == `ISME_OP_LOADLIT) begin
      // bits 9:8 ignored, any value decodes
      op_class = `ISME_CLS_LOADLIT;
    end else begin
      known = 1'b0;
    end
  end

endmodule

/* isme_exec.v */
// execute stage for increment-skip, or-with-file, or-literal, load-literal
`timescale 1ns/100ps
`include "isme_consts.vh"

// What this block does
// - increment-then-skip adds one to the file value and sends it to acc or file by d, flags untouched.
// - a zero increment result discards the fetched next word and runs a no-operation cycle instead.
// - or-with-file ORs acc with the file value, routes by d, updates zero, takes one cycle.
// - load-literal puts the low eight bits into the accumulator in one cycle, flags untouched.
// - the two don't-care bits of load-literal are ignored by the decoder whatever they hold.
// - or-literal ORs acc with the low eight bits into acc, updates zero, takes one cycle.
// - an instruction cycle is four oscillator clocks; skips take two such cycles.
module isme_exec (
  // clock and reset
  input  wire                      clock,
  input  wire                      reset,
  // instruction from fetch
  input  wire                      instr_valid,
  input  wire [`ISME_WORD_W-1:0]   instr_word,
  output wire                      instr_ready,
  // file register read port
  output reg  [`ISME_FADDR_W-1:0]  file_addr_q,
  input  wire [`ISME_DATA_W-1:0]   file_data,
  // file register write port
  output reg                       file_wr_en_q,
  output reg  [`ISME_DATA_W-1:0]   file_wr_data_q,
  // accumulator
  output reg  [`ISME_DATA_W-1:0]   acc_q,
  // zero flag update to status
  output reg                       zero_we_q,
  output reg                       zero_value_q,
  // sequencing status
  output reg  [`ISME_PHASE_W-1:0]  phase_q,
  output reg                       skip_pending_q,
  output reg                       discard_q,
  output reg                       cycle_done_q,
  output reg                       unsupported_q
);

  // phase states of one instruction cycle
  localparam [`ISME_PHASE_W-1:0] PH_TAKE   = 2'h0;
  localparam [`ISME_PHASE_W-1:0] PH_READ   = 2'h1;
  localparam [`ISME_PHASE_W-1:0] PH_CALC   = 2'h2;
  localparam [`ISME_PHASE_W-1:0] PH_COMMIT = 2'h3;

  // instruction cycle length in ns, for reference by users of the block
  localparam integer INSTR_CYCLE_NS =
    `ISME_OSC_PERIOD_NS * `ISME_OSC_PER_INSTR;

  function is_zero;
    input [`ISME_DATA_W-1:0] v;
    begin
      is_zero = (v == {`ISME_DATA_W{1'b0}});
    end
  endfunction

  // latched instruction and decode
  reg  [`ISME_WORD_W-1:0] instr_q;
  reg  [`ISME_CLS_W-1:0]  class_q;
  reg                     dest_file_q;
  reg  [`ISME_DATA_W-1:0] operand_q;
  reg  [`ISME_DATA_W-1:0] result_q;
  reg  [`ISME_DATA_W-1:0] result_d;
  reg  [`ISME_PHASE_W-1:0] phase_d;

  wire [`ISME_CLS_W-1:0]  dec_class;
  wire                    dec_known;
  wire [`ISME_DATA_W-1:0] literal;

  isme_decode u_decode (
    .word     (instr_word),
    .op_class (dec_class),
    .known    (dec_known)
  );

  assign literal = instr_q[`ISME_DATA_W-1:0];

  // word is taken only at the first clock of a cycle
  assign instr_ready = (phase_q == PH_TAKE);

  // free-running phase counter, four clocks per instruction
  always @* begin
    case (phase_q)
      PH_TAKE:   phase_d = PH_READ;
      PH_READ:   phase_d = PH_CALC;
      PH_CALC:   phase_d = PH_COMMIT;
      PH_COMMIT: phase_d = PH_TAKE;
      default:   phase_d = PH_TAKE;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      phase_q <= PH_TAKE;
    end else begin
      phase_q <= phase_d;
    end
  end

  // take stage: a missing word or a skip turns the cycle into a no-op
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      instr_q       <= {`ISME_WORD_W{1'b0}};
      class_q       <= `ISME_CLS_NOP;
      dest_file_q   <= 1'b0;
      file_addr_q   <= {`ISME_FADDR_W{1'b0}};
      discard_q     <= 1'b0;
      unsupported_q <= 1'b0;
    end else begin
      discard_q <= 1'b0;
      if (phase_q == PH_TAKE) begin
        instr_q     <= instr_word;
        dest_file_q <= instr_word[`ISME_DEST_BIT];
        file_addr_q <= instr_word[`ISME_FADDR_W-1:0];
        if (skip_pending_q) begin
          // prefetched word thrown away, no-operation runs
          class_q       <= `ISME_CLS_NOP;
          discard_q     <= instr_valid;
          unsupported_q <= 1'b0;
        end else if (instr_valid) begin
          class_q       <= dec_class;
          unsupported_q <= ~dec_known;
        end else begin
          class_q       <= `ISME_CLS_NOP;
          unsupported_q <= 1'b0;
        end
      end
    end
  end

  // file value sampled while phase is read, address stable since take
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      operand_q <= {`ISME_DATA_W{1'b0}};
    end else if (phase_q == PH_READ) begin
      operand_q <= file_data;
    end
  end

  // arithmetic for each class
  always @* begin
    case (class_q)
      `ISME_CLS_INCSKIP: result_d = operand_q + 8'h01;
      `ISME_CLS_ORFILE:  result_d = acc_q | operand_q;
      `ISME_CLS_ORLIT:   result_d = acc_q | literal;
      `ISME_CLS_LOADLIT: result_d = literal;
      default:           result_d = acc_q;
    endcase
  end

  always @(posedge clock or posedge reset) begin
    if (reset) begin
      result_q <= {`ISME_DATA_W{1'b0}};
    end else if (phase_q == PH_CALC) begin
      result_q <= result_d;
    end
  end

  // commit stage: all writes land on the last clock of the cycle
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      acc_q          <= `ISME_ACC_RESET;
      file_wr_en_q   <= 1'b0;
      file_wr_data_q <= {`ISME_DATA_W{1'b0}};
      zero_we_q      <= 1'b0;
      zero_value_q   <= 1'b0;
      skip_pending_q <= 1'b0;
      cycle_done_q   <= 1'b0;
    end else begin
      file_wr_en_q <= 1'b0;
      zero_we_q    <= 1'b0;
      cycle_done_q <= 1'b0;
      if (phase_q == PH_COMMIT) begin
        cycle_done_q   <= 1'b1;
        file_wr_data_q <= result_q;
        // skip cycle ends here; only a new zero increment re-arms it
        skip_pending_q <= 1'b0;
        case (class_q)
          `ISME_CLS_INCSKIP: begin
            // no zero flag write on increment
            if (dest_file_q) begin
              file_wr_en_q <= 1'b1;
            end else begin
              acc_q <= result_q;
            end
            skip_pending_q <= is_zero(result_q);
          end
          `ISME_CLS_ORFILE: begin
            if (dest_file_q) begin
              file_wr_en_q <= 1'b1;
            end else begin
              acc_q <= result_q;
            end
            zero_we_q    <= 1'b1;
            zero_value_q <= is_zero(result_q);
          end
          `ISME_CLS_ORLIT: begin
            acc_q        <= result_q;
            zero_we_q    <= 1'b1;
            zero_value_q <= is_zero(result_q);
          end
          `ISME_CLS_LOADLIT: begin
            acc_q <= result_q;
          end
          default: begin
            // no-operation and foreign opcodes leave state alone
            acc_q <= acc_q;
          end
        endcase
      end
    end
  end

  // a zero-result write to file still happens before the skip cycle,
  // so the partner sees the wrapped value before the discarded word

endmodule

/* isme_exec_properties.sv */
// concurrent checks on the execute block ports
`timescale 1ns/100ps
module isme_exec_props (
  // clock and reset
  input wire        clock,
  input wire        reset,
  // fetch side
  input wire        instr_valid,
  input wire [13:0] instr_word,
  input wire        instr_ready,
  // file and results
  input wire [7:0]  file_data,
  input wire        file_wr_en_q,
  input wire [7:0]  file_wr_data_q,
  input wire [7:0]  acc_q,
  input wire        zero_we_q,
  input wire        zero_value_q,
  // sequencing
  input wire [1:0]  phase_q,
  input wire        skip_pending_q,
  input wire        discard_q,
  input wire        cycle_done_q,
  input wire        unsupported_q
);
  // a word offered in a skip cycle is dropped, so it is no take
  wire take = instr_ready && instr_valid && !skip_pending_q;
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  ready_phase_a: assert property (instr_ready == (phase_q == 2'h0))
    else $error("ready outside phase zero");
  phase_step_a: assert property (!$past(reset) |->
    phase_q == $past(phase_q) + 2'h1) else $error("phase did not step");
  done_period_a: assert property (cycle_done_q |=>
    !cycle_done_q [*3] ##1 cycle_done_q) else $error("done not every 4");
  lit_load_a: assert property (take && instr_word[13:10] == 4'hc |->
    ##4 acc_q == $past(instr_word[7:0], 4)) else $error("load wrong");
  lit_or_a: assert property (take && instr_word[13:8] == 6'h38 |->
    ##4 acc_q == ($past(acc_q, 4) | $past(instr_word[7:0], 4)) && zero_we_q
    && zero_value_q == (acc_q == 8'h00)) else $error("or literal wrong");
  file_or_a: assert property (take && instr_word[13:8] == 6'h04 |->
    ##4 zero_we_q && ($past(instr_word[7], 4) ? file_wr_en_q &&
    file_wr_data_q == ($past(acc_q, 4) | $past(file_data, 3)) :
    acc_q == ($past(acc_q, 4) | $past(file_data, 3))))
    else $error("or file wrong");
  inc_skip_a: assert property (take && instr_word[13:8] == 6'h0f |->
    ##4 !zero_we_q && file_wr_en_q == $past(instr_word[7], 4) &&
    skip_pending_q == ($past(file_data, 3) == 8'hff))
    else $error("increment wrong");
  skip_drop_a: assert property (skip_pending_q && instr_ready &&
    instr_valid |=> discard_q) else $error("no discard");
  skip_quiet_a: assert property (skip_pending_q && phase_q == 2'h3 |=>
    !file_wr_en_q && !zero_we_q && $stable(acc_q) && !skip_pending_q)
    else $error("skip cycle not idle");
  unsup_flag_a: assert property (take |=>
    unsupported_q == !($past(instr_word[13:8]) == 6'h0f ||
    $past(instr_word[13:8]) == 6'h04 || $past(instr_word[13:8]) == 6'h38 ||
    $past(instr_word[13:10]) == 4'hc)) else $error("unsupported flag wrong");
endmodule
bind isme_exec isme_exec_props i_isme_exec_props (.*);

/* isme_file_model.sv */
// register file model facing the execute block
`timescale 1ns/100ps
module isme_file_model (
  // from execute block
  input  wire       clock,
  input  wire [6:0] file_addr_q,
  input  wire       file_wr_en_q,
  input  wire [7:0] file_wr_data_q,
  // read data
  output wire [7:0] file_data
);
  reg     [7:0] mem [0:127];
  reg     [6:0] wa;
  integer       i;
  initial for (i = 0; i < 128; i = i + 1) mem[i] = {i[6:0], 1'b1};
  assign file_data = mem[file_addr_q];
  // the address may move on at the take edge, so write the held one
  always @(posedge clock) begin
    wa <= file_addr_q;
    if (file_wr_en_q) mem[wa] <= file_wr_data_q;
  end
endmodule

/* testbench.sv */
// self-checking bench for the execute block
`timescale 1ns/100ps
module testbench;
  reg         clock = 0, reset = 1, instr_valid = 0, z_m = 0, skip_m = 0;
  reg  [13:0] instr_word = 0;
  wire        instr_ready, file_wr_en_q, zero_we_q, zero_value_q;
  wire        skip_pending_q, discard_q, cycle_done_q, unsupported_q;
  wire [6:0]  file_addr_q;
  wire [7:0]  file_data, file_wr_data_q, acc_q;
  wire [1:0]  phase_q;
  integer     num_errors = 0, n_compared = 0, seed = 32'hf659, i, k;
  reg  [7:0]  acc_m = 0, fwd_m = 0, mir [0:127];
  reg  [31:0] rnd;
  reg  [19:0] exp_q [$];
  reg  [14:0] dir [13] = '{15'h709a, 15'h7835, 15'h7300, 15'h7800,
    15'h44ff, 15'h4fff, 15'h7055, 15'h4f7f, 15'h70ff, 15'h44ff, 15'h4f7f,
    15'h3011, 15'h5234};
  reg  [13:0] base [5] = '{14'h0f00, 14'h0400, 14'h3800, 14'h3000, 14'h0};
  reg  [13:0] msk [5] = '{14'hff, 14'hff, 14'hff, 14'h3ff, 14'h3fff};
  isme_exec i_isme_exec (.*);
  isme_file_model i_isme_file_model (.*);
  always #5 clock = ~clock;
  task check(input [19:0] seen, input [19:0] want);
    begin
      n_compared = n_compared + 1;
      if (seen !== want) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %0t seen %h want %h", $time, seen, want);
      end
    end
  endtask
  task end_sim;
    begin
      if (num_errors == 0 && n_compared > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // one instruction cycle; the model is updated as the word is offered
  task issue(input v, input [13:0] w);
    reg       zw, fw;
    reg [1:0] dm;
    reg [7:0] r;
    begin
      zw = 0;
      fw = 0;
      dm = 0;
      // no-ops and acc-bound results still put a value on the write data
      r = acc_m;
      check(instr_ready, 20'h1);
      instr_valid = v;
      instr_word = w;
      if (skip_m) skip_m = 0;
      else if (v) begin
        if (w[13:8] == 6'h0f) begin
          r = mir[w[6:0]] + 8'h01;
          skip_m = (r == 8'h00);
          dm = 2;
        end else if (w[13:8] == 6'h04) begin
          r = acc_m | mir[w[6:0]];
          zw = 1;
          dm = 2;
        end else if (w[13:8] == 6'h38) begin
          r = acc_m | w[7:0];
          zw = 1;
          dm = 1;
        end else if (w[13:10] == 4'hc) begin
          r = w[7:0];
          dm = 1;
        end
        if (dm == 2 && w[7]) begin
          fw = 1;
          mir[w[6:0]] = r;
        end else if (dm != 0) acc_m = r;
        if (zw) z_m = (r == 8'h00);
      end
      fwd_m = r;
      exp_q.push_back({acc_m, zw, z_m, fw, fwd_m, skip_m});
      @(posedge clock);
      #1 instr_word = $random(seed);
      repeat (3) @(posedge clock);
      #1;
    end
  endtask
  always @(negedge clock)
    if (!reset && cycle_done_q === 1'b1)
      check({acc_q, zero_we_q, zero_value_q, file_wr_en_q, file_wr_data_q,
        skip_pending_q}, exp_q.size() ? exp_q.pop_front() : 20'hx);
  initial begin
    for (i = 0; i < 128; i = i + 1) mir[i] = {i[6:0], 1'b1};
    repeat (12) @(posedge clock);
    check({acc_q, file_wr_en_q, zero_we_q, cycle_done_q, phase_q}, 20'h0);
    #1 reset = 0;
    for (i = 0; i < 13; i = i + 1) issue(dir[i][14], dir[i][13:0]);
    for (i = 0; i < 400; i = i + 1) begin
      rnd = $random(seed);
      k = rnd[31:29] % 5;
      issue(|rnd[27:26], base[k] | (rnd[13:0] & msk[k]));
    end
    @(negedge clock);
    #1 end_sim;
  end
  // a hang would stop the done pulses
  initial begin
    #60000;
    num_errors = num_errors + 1;
    end_sim;
  end
endmodule
